// ### src/psc_pkg.sv
package psc_pkg;
  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_KEY_SP    = 8'h04;
  localparam logic [7:0] OFS_FB_LOW    = 8'h08;
  localparam logic [7:0] OFS_FB_HIGH   = 8'h0c;
  localparam logic [7:0] OFS_KP        = 8'h10;
  localparam logic [7:0] OFS_KI        = 8'h14;
  localparam logic [7:0] OFS_KD        = 8'h18;
  localparam logic [7:0] OFS_RAMP      = 8'h1c;
  localparam logic [7:0] OFS_LOW_ALM   = 8'h20;
  localparam logic [7:0] OFS_UP_ALM    = 8'h24;
  localparam logic [7:0] OFS_DIN_FUNC  = 8'h28;
  localparam logic [7:0] OFS_KEY_SPEED = 8'h2c;
  localparam logic [7:0] OFS_STATUS    = 8'h30;
  localparam logic [7:0] OFS_INT_STAT  = 8'h34;
  localparam logic [7:0] OFS_INT_MASK  = 8'h38;
  localparam logic [7:0] OFS_PV        = 8'h3c;
  // ------------------------------------------------------------
  // Control fields and reset values
  // ------------------------------------------------------------
  localparam int CTRL_ACT_LSB   = 0;
  localparam int CTRL_AUTO      = 2;
  localparam int CTRL_REMOTE    = 3;
  localparam int CTRL_FB_CUR    = 4;
  localparam int CTRL_MM_START  = 5;
  localparam logic [5:0]  CTRL_RST  = 6'h00;
  localparam logic [15:0] WORD_RST  = 16'h0000;
  localparam logic [15:0] UP_ALM_RST = 16'hffff;
  localparam int INT_W          = 3;
  localparam int INT_UPPER      = 0;
  localparam int INT_STOP       = 1;
  localparam int INT_CLAMP      = 2;
  // ------------------------------------------------------------
  // Modes and encodings
  // ------------------------------------------------------------
  typedef enum logic [1:0] {ACT_OFF, ACT_DIRECT, ACT_REVERSE, ACT_RSVD} psc_act_type;
  localparam logic [1:0] DIN_NONE = 2'h0;
  localparam logic [1:0] DIN_VSP  = 2'h1;
  localparam logic [1:0] DIN_ISP  = 2'h2;
  localparam logic [1:0] DIN_POT  = 2'h3;
  // ------------------------------------------------------------
  // Analog scaling and timing
  // ------------------------------------------------------------
  localparam logic [11:0] CUR_ZERO_CODE = 12'h333;
  localparam logic [4:0]  CUR_GAIN      = 5'h14;
  localparam logic [15:0] SPEED_MAX     = 16'hffff;
  localparam int CLK_MHZ       = 50;
  localparam int SAMPLE_US     = 1000;
  localparam int SAMPLE_CYC    = SAMPLE_US * CLK_MHZ;
  localparam int GAIN_SHIFT    = 8;
endpackage

// ### src/psc_scaler.sv
`timescale 1ns/100ps
module psc_scaler
  import psc_pkg::*;
(
  input  wire logic        i_core_clk, // System clock
  input  wire logic        i_rst,      // Sync reset
  input  wire logic [15:0] i_frac,     // Input, 0..ffff of span
  input  wire logic [15:0] i_low,      // Value at minimum signal
  input  wire logic [15:0] i_high,     // Value at maximum signal
  output logic      [15:0] o_value     // Scaled process value
);
  logic signed [16:0] span;
  logic        [16:0] frac_ext;
  logic signed [34:0] prod;
  logic signed [34:0] sum;
  logic        [15:0] o_value_next;

  // Low above high gives a falling slope: inverted transducer
  assign span         = $signed({1'b0, i_high}) - $signed({1'b0, i_low});
  // Full-scale code stretched to 1.0 so it lands exactly on the high value
  assign frac_ext     = {1'b0, i_frac} + {16'h0, i_frac[15]};
  assign prod         = 35'(span * $signed({1'b0, frac_ext}));
  assign sum          = (prod >>> 16) + $signed({19'h0, i_low});
  assign o_value_next = sum[15:0];

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      o_value <= WORD_RST;
    else
      o_value <= o_value_next;
  end
endmodule

// ### src/psc_ramp.sv
`timescale 1ns/100ps
module psc_ramp
  import psc_pkg::*;
(
  input  wire logic        i_core_clk, // System clock
  input  wire logic        i_rst,      // Sync reset
  input  wire logic        i_tick,     // Loop sample strobe
  input  wire logic [15:0] i_step,     // Step per sample, 0 = off
  input  wire logic [15:0] i_target,   // Requested set point
  output logic      [15:0] o_value     // Set point into the loop
);
  logic [16:0] up_sum;
  logic [15:0] o_value_next;

  assign up_sum = {1'b0, o_value} + {1'b0, i_step};

  always_comb
  begin
    o_value_next = o_value;
    if (i_step == WORD_RST)
      o_value_next = i_target;
    else if (i_tick && o_value < i_target)
      o_value_next = (up_sum[15:0] > i_target || up_sum[16]) ? i_target : up_sum[15:0];
    else if (i_tick && o_value > i_target)
      o_value_next = (o_value - i_target < i_step) ? i_target : o_value - i_step;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      o_value <= WORD_RST;
    else
      o_value <= o_value_next;
  end
endmodule

// ### src/psc_ctrl.sv
// Chosen here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
module psc_ctrl
  import psc_pkg::*;
#(
  parameter int P_SAMPLE_CYC = SAMPLE_CYC // Clocks per loop sample
)(
  input  wire logic        i_core_clk,     // 50 MHz system clock
  input  wire logic        i_rst,          // Sync reset, active high
  input  wire logic        i_wb_cyc,       // Wishbone cycle
  input  wire logic        i_wb_stb,       // Wishbone strobe
  input  wire logic        i_wb_we,        // Wishbone write
  input  wire logic [7:0]  i_wb_adr,       // Byte address
  input  wire logic [3:0]  i_wb_sel,       // Byte enables
  input  wire logic [31:0] i_wb_dat,       // Write data
  output logic      [31:0] o_wb_dat,       // Read data
  output logic             o_wb_ack,       // Acknowledge
  input  wire logic [11:0] i_voltage_adc,  // Voltage analog input code
  input  wire logic [11:0] i_current_adc,  // Current analog input code
  input  wire logic [2:0]  i_din_n,        // Digital inputs a..c, low = closed
  output logic      [15:0] o_speed_cmd,    // Speed command to motor control
  output logic             o_upper_alarm,  // Upper alarm output
  output logic             o_minmax_alarm, // Min/max alarm output, high = energized
  output logic             o_run_request,  // Start from min/max, remote only
  output logic             o_irq           // Level interrupt
);
  // ------------------------------------------------------------
  // Registers and wires
  // ------------------------------------------------------------
  logic [5:0]  ctrl_reg;
  logic [15:0] key_sp_reg, fb_low_reg, fb_high_reg, kp_reg, ki_reg, kd_reg;
  logic [15:0] ramp_reg, low_alm_reg, up_alm_reg, key_speed_reg;
  logic [5:0]  din_func_reg;
  logic [INT_W-1:0] int_stat_reg, int_mask_reg, int_set;
  logic [2:0]  din_meta_reg, din_sync_reg;
  logic        ack_reg;
  logic [31:0] rdat_reg, rdat_next;
  logic [16:0] tick_cnt_reg;
  logic        tick;
  logic [31:0] wmask;
  logic        wr_en, rd_en;
  psc_act_type act;
  logic        auto_mode, remote_mode, fb_cur, loop_closed;
  logic [15:0] volt_frac, cur_frac, fb_frac, sp_frac;
  logic [16:0] cur_raw;
  logic [21:0] cur_prod;
  logic [15:0] pv, sp_scaled, sp_target, sp_loop;
  logic [2:0]  din_closed;
  logic        want_v, want_i, use_v_sp, use_i_sp;
  logic signed [16:0] err, act_err, act_err_prev_reg;
  logic signed [17:0] dlt;
  logic signed [35:0] p_term, i_inc, d_term, integ_reg, integ_next, pid_sum;
  logic [15:0] open_ref, speed_reg, speed_next;
  logic        clamp_evt, upper_reg, minmax_reg;
  logic        upper_prev_reg, minmax_prev_reg;

  // ------------------------------------------------------------
  // Wishbone slave, one wait state
  // ------------------------------------------------------------
  assign wmask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
  // Write lands on the edge where the master sees ack
  assign wr_en = i_wb_cyc && i_wb_stb && i_wb_we && ack_reg;
  assign rd_en = i_wb_cyc && i_wb_stb && !ack_reg;
  assign o_wb_ack = ack_reg;
  assign o_wb_dat = rdat_reg;

  function automatic logic [15:0] upd16(input logic [15:0] old, input logic [31:0] d,
                                        input logic [31:0] m);
    upd16 = (old & ~m[15:0]) | (d[15:0] & m[15:0]);
  endfunction

  always_comb
  begin
    case (i_wb_adr)
      OFS_CTRL:      rdat_next = {26'h0, ctrl_reg};
      OFS_KEY_SP:    rdat_next = {16'h0, key_sp_reg};
      OFS_FB_LOW:    rdat_next = {16'h0, fb_low_reg};
      OFS_FB_HIGH:   rdat_next = {16'h0, fb_high_reg};
      OFS_KP:        rdat_next = {16'h0, kp_reg};
      OFS_KI:        rdat_next = {16'h0, ki_reg};
      OFS_KD:        rdat_next = {16'h0, kd_reg};
      OFS_RAMP:      rdat_next = {16'h0, ramp_reg};
      OFS_LOW_ALM:   rdat_next = {16'h0, low_alm_reg};
      OFS_UP_ALM:    rdat_next = {16'h0, up_alm_reg};
      OFS_DIN_FUNC:  rdat_next = {26'h0, din_func_reg};
      OFS_KEY_SPEED: rdat_next = {16'h0, key_speed_reg};
      OFS_STATUS:    rdat_next = {10'h0, loop_closed, use_i_sp, use_v_sp,
                                  o_run_request, minmax_reg, upper_reg, speed_reg};
      OFS_INT_STAT:  rdat_next = {29'h0, int_stat_reg};
      OFS_INT_MASK:  rdat_next = {29'h0, int_mask_reg};
      OFS_PV:        rdat_next = {sp_loop, pv};
      default:       rdat_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end
    else
    begin
      ack_reg  <= i_wb_cyc && i_wb_stb && !ack_reg;
      if (rd_en)
        rdat_reg <= rdat_next;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      ctrl_reg      <= CTRL_RST;
      key_sp_reg    <= WORD_RST;
      fb_low_reg    <= WORD_RST;
      fb_high_reg   <= SPEED_MAX;
      kp_reg        <= WORD_RST;
      ki_reg        <= WORD_RST;
      kd_reg        <= WORD_RST;
      ramp_reg      <= WORD_RST;
      low_alm_reg   <= WORD_RST;
      up_alm_reg    <= UP_ALM_RST;
      din_func_reg  <= CTRL_RST;
      key_speed_reg <= WORD_RST;
      int_mask_reg  <= '0;
    end
    else if (wr_en)
    begin
      case (i_wb_adr)
        OFS_CTRL:      ctrl_reg      <= (ctrl_reg & ~wmask[5:0]) | (i_wb_dat[5:0] & wmask[5:0]);
        OFS_KEY_SP:    key_sp_reg    <= upd16(key_sp_reg, i_wb_dat, wmask);
        OFS_FB_LOW:    fb_low_reg    <= upd16(fb_low_reg, i_wb_dat, wmask);
        OFS_FB_HIGH:   fb_high_reg   <= upd16(fb_high_reg, i_wb_dat, wmask);
        OFS_KP:        kp_reg        <= upd16(kp_reg, i_wb_dat, wmask);
        OFS_KI:        ki_reg        <= upd16(ki_reg, i_wb_dat, wmask);
        OFS_KD:        kd_reg        <= upd16(kd_reg, i_wb_dat, wmask);
        OFS_RAMP:      ramp_reg      <= upd16(ramp_reg, i_wb_dat, wmask);
        OFS_LOW_ALM:   low_alm_reg   <= upd16(low_alm_reg, i_wb_dat, wmask);
        OFS_UP_ALM:    up_alm_reg    <= upd16(up_alm_reg, i_wb_dat, wmask);
        OFS_DIN_FUNC:  din_func_reg  <= (din_func_reg & ~wmask[5:0])
                                        | (i_wb_dat[5:0] & wmask[5:0]);
        OFS_KEY_SPEED: key_speed_reg <= upd16(key_speed_reg, i_wb_dat, wmask);
        OFS_INT_MASK:  int_mask_reg  <= (int_mask_reg & ~wmask[INT_W-1:0])
                                        | (i_wb_dat[INT_W-1:0] & wmask[INT_W-1:0]);
        default:       ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Interrupts: set beats write-one-to-clear
  // ------------------------------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      int_stat_reg <= '0;
    else if (wr_en && i_wb_adr == OFS_INT_STAT)
      int_stat_reg <= (int_stat_reg & ~(i_wb_dat[INT_W-1:0] & wmask[INT_W-1:0])) | int_set;
    else
      int_stat_reg <= int_stat_reg | int_set;
  end

  assign int_set[INT_UPPER] = upper_reg && !upper_prev_reg;
  assign int_set[INT_STOP]  = !minmax_reg && minmax_prev_reg;
  assign int_set[INT_CLAMP] = clamp_evt;
  assign o_irq = |(int_stat_reg & int_mask_reg);

  // ------------------------------------------------------------
  // Digital input synchroniser and sample timer
  // ------------------------------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      din_meta_reg <= 3'h7;
      din_sync_reg <= 3'h7;
      tick_cnt_reg <= '0;
    end
    else
    begin
      din_meta_reg <= i_din_n;
      din_sync_reg <= din_meta_reg;
      tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 17'h1;
    end
  end

  assign tick       = tick_cnt_reg == 17'(P_SAMPLE_CYC - 1);
  assign din_closed = ~din_sync_reg;

  // ------------------------------------------------------------
  // Modes and input selection
  // ------------------------------------------------------------
  assign act         = psc_act_type'(ctrl_reg[CTRL_ACT_LSB +: 2]);
  assign auto_mode   = ctrl_reg[CTRL_AUTO];
  assign remote_mode = ctrl_reg[CTRL_REMOTE];
  assign fb_cur      = ctrl_reg[CTRL_FB_CUR];
  // Only auto mode with an active loop action closes the loop
  assign loop_closed = auto_mode && (act == ACT_DIRECT || act == ACT_REVERSE);

  // Current input: 4 mA code is zero, 20 mA full scale
  assign cur_raw   = (i_current_adc > CUR_ZERO_CODE) ? 17'(i_current_adc - CUR_ZERO_CODE) : '0;
  assign cur_prod  = 22'(cur_raw * CUR_GAIN);
  // Top bits folded into the bottom so full-scale codes reach ffff
  assign cur_frac  = cur_prod[15:0] + {12'h0, cur_prod[15:12]};
  assign volt_frac = {i_voltage_adc, i_voltage_adc[11:8]};
  assign fb_frac   = fb_cur ? cur_frac : volt_frac;

  // Set point source from closed digital inputs, remote only
  assign want_v = (din_closed[0] && (din_func_reg[1:0] == DIN_VSP || din_func_reg[1:0] == DIN_POT))
               || (din_closed[1] && (din_func_reg[3:2] == DIN_VSP || din_func_reg[3:2] == DIN_POT))
               || (din_closed[2] && (din_func_reg[5:4] == DIN_VSP || din_func_reg[5:4] == DIN_POT));
  assign want_i = (din_closed[0] && din_func_reg[1:0] == DIN_ISP)
               || (din_closed[1] && din_func_reg[3:2] == DIN_ISP)
               || (din_closed[2] && din_func_reg[5:4] == DIN_ISP);
  // Feedback input is never borrowed for the set point
  assign use_v_sp  = remote_mode && want_v && fb_cur;
  assign use_i_sp  = remote_mode && want_i && !use_v_sp && !fb_cur;
  assign sp_frac   = use_i_sp ? cur_frac : volt_frac;
  assign sp_target = (use_v_sp || use_i_sp) ? sp_scaled : key_sp_reg;

  psc_scaler u_fb_scale (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_frac     (fb_frac),
    .i_low      (fb_low_reg),
    .i_high     (fb_high_reg),
    .o_value    (pv)
  );

  psc_scaler u_sp_scale (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_frac     (sp_frac),
    .i_low      (fb_low_reg),
    .i_high     (fb_high_reg),
    .o_value    (sp_scaled)
  );

  psc_ramp u_sp_ramp (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_tick     (tick),
    .i_step     (ramp_reg),
    .i_target   (sp_target),
    .o_value    (sp_loop)
  );

  // ------------------------------------------------------------
  // Loop arithmetic
  // ------------------------------------------------------------
  assign err     = $signed({1'b0, pv}) - $signed({1'b0, sp_loop});
  // Direct wants speed up when feedback is low, so negate
  assign act_err = (act == ACT_REVERSE) ? err : -err;
  assign dlt     = 18'(act_err) - 18'(act_err_prev_reg);
  assign p_term  = 36'(($signed({1'b0, kp_reg}) * act_err) >>> GAIN_SHIFT);
  assign i_inc   = 36'(($signed({1'b0, ki_reg}) * act_err) >>> GAIN_SHIFT);
  assign d_term  = 36'(($signed({1'b0, kd_reg}) * dlt) >>> GAIN_SHIFT);
  // Integrator held inside the speed range, avoids windup
  always_comb
  begin
    integ_next = integ_reg + i_inc;
    if (integ_next < 0)
      integ_next = '0;
    else if (integ_next > $signed({20'h0, SPEED_MAX}))
      integ_next = $signed({20'h0, SPEED_MAX});
  end
  assign pid_sum  = p_term + integ_next + d_term;
  assign open_ref = (auto_mode) ? fb_frac : key_speed_reg;

  always_comb
  begin
    speed_next = open_ref;
    clamp_evt  = 1'b0;
    if (loop_closed)
    begin
      if (pid_sum < 0)
      begin
        speed_next = '0;
        clamp_evt  = tick;
      end
      else if (pid_sum > $signed({20'h0, SPEED_MAX}))
      begin
        speed_next = SPEED_MAX;
        clamp_evt  = tick;
      end
      else
        speed_next = pid_sum[15:0];
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      speed_reg        <= WORD_RST;
      integ_reg        <= '0;
      act_err_prev_reg <= '0;
    end
    else if (tick)
    begin
      speed_reg        <= speed_next;
      integ_reg        <= loop_closed ? integ_next : '0;
      act_err_prev_reg <= act_err;
    end
  end

  assign o_speed_cmd = speed_reg;

  // ------------------------------------------------------------
  // Alarms
  // ------------------------------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      upper_reg       <= 1'b0;
      minmax_reg      <= 1'b0;
      upper_prev_reg  <= 1'b0;
      minmax_prev_reg <= 1'b0;
    end
    else
    begin
      upper_reg       <= pv > up_alm_reg;
      minmax_reg      <= pv >= low_alm_reg;
      upper_prev_reg  <= upper_reg;
      minmax_prev_reg <= minmax_reg;
    end
  end

  assign o_upper_alarm  = upper_reg;
  assign o_minmax_alarm = minmax_reg;
  assign o_run_request  = remote_mode && ctrl_reg[CTRL_MM_START] && minmax_reg;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  sequence s_tick_closed;
    tick && loop_closed;
  endsequence
  sequence s_tick_open;
    tick && !loop_closed;
  endsequence

  a_upper_set: assert property ((pv > up_alm_reg) |=> o_upper_alarm)
    else $error("upper alarm missed");
  a_upper_clear: assert property (!(pv > up_alm_reg) |=> !o_upper_alarm)
    else $error("upper alarm false");
  a_minmax_level: assert property ((pv < low_alm_reg) |=> !o_minmax_alarm)
    else $error("minmax energized below low");
  a_remote_only: assert property (!remote_mode |-> !o_run_request)
    else $error("run request outside remote");
  a_sp_not_fb: assert property (!(use_i_sp && fb_cur) && !(use_v_sp && !fb_cur))
    else $error("feedback input used as set point");
  a_open_follow: assert property (s_tick_open |=> o_speed_cmd == $past(open_ref))
    else $error("open loop speed wrong");
  a_integ_rise: assert property (s_tick_closed ##0 (act_err > 0 && ki_reg > 16'h0100
      && integ_reg < 36'sh0_0000_f000) |=> integ_reg > $past(integ_reg))
    else $error("integral did not rise");
  a_ramp_off: assert property ((ramp_reg == 16'h0000) ##1 (ramp_reg == 16'h0000)
      |-> sp_loop == $past(sp_target))
    else $error("ramp not bypassed");
  a_local_keypad: assert property (!remote_mode |-> sp_target == key_sp_reg)
    else $error("analog set point in local");
endmodule

// ### tb/psc_source_model.sv
`timescale 1ns/100ps
module psc_source_model
(
  input  wire logic [11:0] i_v_code,      // Requested voltage level
  input  wire logic [11:0] i_c_code,      // Requested loop current
  input  wire logic [2:0]  i_closed,      // Contacts closed to common
  output logic      [11:0] o_voltage_adc, // Voltage input code
  output logic      [11:0] o_current_adc, // Current input code
  output logic      [2:0]  o_din_n        // Digital inputs, low = closed
);
  assign o_voltage_adc = i_v_code;
  // Live 4-20 mA loop never sits below 4 mA
  assign o_current_adc = (i_c_code < 12'h333) ? 12'h333 : i_c_code;
  assign o_din_n = ~i_closed;
endmodule

// ### tb/tb_pid_setpoint_speed_control.sv
`timescale 1ns/100ps
module tb_pid_setpoint_speed_control;
  import psc_pkg::*;
  localparam int SMP = 16;
  logic        core_clk, rst, cyc, stb, we, ack, irq, upper, minmax, run;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, q;
  logic [11:0] v_code, c_code, v_adc, c_adc;
  logic [2:0]  closed, din_n;
  logic [15:0] speed;
  int          n_fail, n_tests;
  logic [5:0]  sp_ctrl [6] = '{6'h18, 6'h18, 6'h08, 6'h08, 6'h18, 6'h10};
  logic [2:0]  sp_cl [6]   = '{3'h1, 3'h0, 3'h1, 3'h2, 3'h4, 3'h1};
  logic [31:0] sp_exp [6]  = '{32'h80000, 32'h0, 32'h0, 32'h100000, 32'h80000, 32'h0};

  psc_source_model u_src (.i_v_code(v_code), .i_c_code(c_code), .i_closed(closed),
    .o_voltage_adc(v_adc), .o_current_adc(c_adc), .o_din_n(din_n));
  psc_ctrl #(.P_SAMPLE_CYC(SMP)) u_dut (.i_core_clk(core_clk), .i_rst(rst), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_voltage_adc(v_adc), .i_current_adc(c_adc),
    .i_din_n(din_n), .o_speed_cmd(speed), .o_upper_alarm(upper), .o_minmax_alarm(minmax),
    .o_run_request(run), .o_irq(irq));

  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // ----------------
  // Bus and checks
  // ----------------
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    @(posedge core_clk);
    while (ack !== 1'b1)
      @(posedge core_clk);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m, e);
    wb(1'b0, a, 32'h0);
    chk(nm, q & m, e);
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Whole run needs under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    complete_run;
  end
  // ----------------
  // Tests
  // ----------------
  initial
  begin
    {rst, cyc, stb, we, adr, sel, wdat, v_code, c_code, closed} = '0;
    rst = 1'b1;
    n_fail = 0;
    n_tests = 0;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rdc("high scale", OFS_FB_HIGH, 32'hffff, 32'hffff);
    rdc("upper thr", OFS_UP_ALM, 32'hffff, 32'hffff);
    rdc("unmapped", 8'h40, 32'hffffffff, 32'h0);
    $display("reset test done");
    wr(OFS_FB_LOW, 32'h1000);
    wr(OFS_FB_HIGH, 32'h5000);
    waitc(4);
    rdc("pv at min", OFS_PV, 32'hffff, 32'h1000);
    v_code <= 12'hfff;
    waitc(4);
    rdc("pv at max", OFS_PV, 32'hffff, 32'h5000);
    wr(OFS_FB_HIGH, 32'h1000);
    wr(OFS_FB_LOW, 32'h5000);
    v_code <= 12'h000;
    waitc(4);
    rdc("pv inverted", OFS_PV, 32'hffff, 32'h5000);
    c_code <= 12'hfff;
    wr(OFS_CTRL, 32'h10);
    waitc(4);
    rdc("pv current", OFS_PV, 32'hffff, 32'h1000);
    $display("scaling test done");
    wr(OFS_CTRL, 32'h20);
    wr(OFS_FB_LOW, 32'h0);
    wr(OFS_FB_HIGH, 32'hffff);
    wr(OFS_LOW_ALM, 32'hffff);
    wr(OFS_INT_MASK, 32'h1);
    v_code <= 12'hfff;
    waitc(4);
    chk("upper at equal", upper, 1'b0);
    chk("minmax at equal", minmax, 1'b1);
    chk("run local", run, 1'b0);
    wr(OFS_UP_ALM, 32'hfffe);
    waitc(4);
    chk("upper above", upper, 1'b1);
    chk("irq", irq, 1'b1);
    wr(OFS_CTRL, 32'h28);
    chk("run remote", run, 1'b1);
    v_code <= 12'h000;
    waitc(4);
    chk("minmax below", minmax, 1'b0);
    chk("run stopped", run, 1'b0);
    rdc("int upper", OFS_INT_STAT, 32'h3, 32'h3);
    wr(OFS_INT_STAT, 32'h1);
    rdc("int cleared", OFS_INT_STAT, 32'h1, 32'h0);
    chk("irq low", irq, 1'b0);
    $display("alarm test done");
    wr(OFS_DIN_FUNC, 32'h39);
    for (int i = 0; i < 6; i++)
    begin
      wr(OFS_CTRL, {26'h0, sp_ctrl[i]});
      closed <= sp_cl[i];
      waitc(4);
      rdc("sp source", OFS_STATUS, 32'h180000, sp_exp[i]);
    end
    closed <= 3'h0;
    $display("set point source test done");
    wr(OFS_KEY_SP, 32'h8000);
    wr(OFS_KP, 32'h100);
    wr(OFS_CTRL, 32'h5);
    waitc(4 * SMP);
    chk("direct speed", {16'h0, speed}, 32'h8000);
    wr(OFS_CTRL, 32'h6);
    waitc(4 * SMP);
    chk("reverse speed", {16'h0, speed}, 32'h0);
    rdc("int clamp", OFS_INT_STAT, 32'h4, 32'h4);
    wr(OFS_KEY_SPEED, 32'h1234);
    wr(OFS_CTRL, 32'h2);
    waitc(4 * SMP);
    chk("manual speed", {16'h0, speed}, 32'h1234);
    v_code <= 12'hfff;
    wr(OFS_CTRL, 32'h4);
    waitc(4 * SMP);
    chk("open loop speed", {16'h0, speed}, 32'hffff);
    v_code <= 12'h000;
    wr(OFS_CTRL, 32'h5);
    wr(OFS_RAMP, 32'h100);
    wr(OFS_KI, 32'h200);
    wr(OFS_KEY_SP, 32'h9000);
    waitc(3 * SMP);
    wb(1'b0, OFS_PV, 32'h0);
    chk("ramp moving", {31'h0, q[31:16] !== 16'h9000}, 32'h1);
    waitc(20 * SMP);
    rdc("ramp done", OFS_PV, 32'hffff0000, 32'h90000000);
    $display("loop test done");
    complete_run;
  end
endmodule
